// ### src/serial_if_map.vh
// register map, field positions, reset values and counts of the serial interface
`ifndef SERIAL_IF_MAP_VH
`define SERIAL_IF_MAP_VH

// ========================================
// register byte addresses
`define ADDR_STATUS 32'hffff_0a00
`define ADDR_RX 32'hffff_0a04
`define ADDR_TX 32'hffff_0a08
`define ADDR_DIV 32'hffff_0a0c
`define ADDR_CTRL 32'hffff_0a10
`define ADDR_ISTAT 32'hffff_0a14
`define ADDR_IMASK 32'hffff_0a18

// ========================================
// reset values
`define RST_STATUS 8'h00
`define RST_RX 8'h00
`define RST_DIV 8'h1b
`define RST_CTRL 9'h000
`define RST_IRQ 4'h0

// ========================================
// status bits
`define ST_OVF 5
`define ST_RXIRQ 4
`define ST_RXFULL 3
`define ST_UNDF 2
`define ST_TXIRQ 1
`define ST_BUSY 0

// ========================================
// control bits
`define CT_EN 0
`define CT_MASTER 1
`define CT_CPHA 2
`define CT_CPOL 3
`define CT_LSB 5
`define CT_TMODE 6
`define CT_UMODE 7
`define CT_OVW 8

// ========================================
// interrupt status bits
`define IS_RX 0
`define IS_TX 1
`define IS_OVF 2
`define IS_UNDF 3

// ========================================
// transfer counts
`define HALF_LAST 4'hf
`define HALF_FIRST 4'h0

`endif

// ### src/sync_2ff.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none

module sync_2ff #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire ce_in,
  input wire [WIDTH-1:0] d_in,
  output wire [WIDTH-1:0] q_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else if (ce_in) begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;

endmodule

`default_nettype wire

// ### src/serial_clock_gen.v
// half-period tick generator for the serial clock
`timescale 1ns/1ns
`default_nettype none

module serial_clock_gen (
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire ce_in,
  input wire run_in,
  input wire [7:0] divider_in,
  output wire tick_out
);

  reg [7:0] cnt_q;
  reg tick_q;

  // half period is divider plus one system cycles
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (ce_in) begin
      if (!run_in) begin
        cnt_q <= 8'h00;
        tick_q <= 1'b0;
      end else if (cnt_q >= divider_in) begin
        cnt_q <= 8'h00;
        tick_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 8'h01;
        tick_q <= 1'b0;
      end
    end
  end

  assign tick_out = tick_q;

endmodule

`default_nettype wire

// ### src/serial_if_regs.v
// serial interface status, data and divider registers with shift engine
`timescale 1ns/1ns
`default_nettype none
`include "serial_if_map.vh"

module serial_if_regs (
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire ce_in,
  input wire [31:0] address_in,
  input wire read_in,
  input wire write_in,
  input wire [31:0] writedata_in,
  output wire [31:0] readdata_out,
  output wire waitrequest_out,
  output wire irq_out,
  input wire sclk_in,
  output wire sclk_out,
  output wire sclk_oe_out,
  input wire mosi_in,
  output wire mosi_out,
  output wire mosi_oe_out,
  input wire miso_in,
  output wire miso_out,
  output wire miso_oe_out,
  input wire ss_n_in,
  output wire ss_n_out
);

  // ========================================
  // state
  reg waitrequest_q;
  reg [31:0] readdata_q;
  reg [8:0] ctrl_q;
  reg [7:0] div_q;
  reg [7:0] rx_q;
  reg [7:0] tx_hold_q;
  reg [7:0] last_tx_q;
  reg tx_full_q;
  reg busy_q;
  reg undf_q;
  reg tx_irq_q;
  reg rx_full_q;
  reg ovf_q;
  reg rx_irq_q;
  reg [3:0] istat_q;
  reg [3:0] imask_q;
  reg irq_q;
  reg active_q;
  reg [3:0] half_q;
  reg [7:0] tx_sh_q;
  reg [7:0] rx_sh_q;
  reg sclk_prev_q;
  reg ss_prev_q;
  reg sclk_q;
  reg sclk_oe_q;
  reg mosi_q;
  reg mosi_oe_q;
  reg miso_q;
  reg miso_oe_q;
  reg ss_n_q;

  // ========================================
  // pin synchronisers
  wire [3:0] pin_s;
  wire ss_s;
  wire sclk_s;
  wire mosi_s;
  wire miso_s;

  sync_2ff #(.WIDTH(4), .RESET_VAL(4'h8)) u_pin_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .d_in({ss_n_in, sclk_in, mosi_in, miso_in}),
    .q_out(pin_s)
  );

  assign ss_s = pin_s[3];
  assign sclk_s = pin_s[2];
  assign mosi_s = pin_s[1];
  assign miso_s = pin_s[0];

  // ========================================
  // bus decode
  wire acc = (read_in | write_in) & waitrequest_q;
  wire rd_acc = acc & read_in;
  wire wr_acc = acc & write_in;
  wire rx_read = rd_acc & (address_in == `ADDR_RX);
  wire istat_read = rd_acc & (address_in == `ADDR_ISTAT);
  wire tx_write = wr_acc & (address_in == `ADDR_TX);
  wire div_write = wr_acc & (address_in == `ADDR_DIV);
  wire ctrl_write = wr_acc & (address_in == `ADDR_CTRL);
  wire imask_write = wr_acc & (address_in == `ADDR_IMASK);

  // ========================================
  // control fields
  wire en = ctrl_q[`CT_EN];
  wire master = en & ctrl_q[`CT_MASTER];
  wire slave = en & ~ctrl_q[`CT_MASTER];
  wire cpha = ctrl_q[`CT_CPHA];
  wire cpol = ctrl_q[`CT_CPOL];
  wire lsb = ctrl_q[`CT_LSB];
  wire tmode = ctrl_q[`CT_TMODE];
  wire umode = ctrl_q[`CT_UMODE];
  wire ovw = ctrl_q[`CT_OVW];

  // ========================================
  // serial clock and edges
  wire tick;

  serial_clock_gen u_clock_gen (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .run_in(active_q & master),
    .divider_in(div_q),
    .tick_out(tick)
  );

  wire sl_edge = slave & active_q & ~ss_s & (sclk_s ^ sclk_prev_q);
  wire edge_ev = active_q & (master ? tick : sl_edge);
  wire leading = edge_ev & ~half_q[0];
  wire trailing = edge_ev & half_q[0];
  wire sample = cpha ? trailing : leading;
  wire shift = cpha ? (leading & (half_q != `HALF_FIRST)) : (trailing & (half_q != `HALF_LAST));
  wire done = edge_ev & (half_q == `HALF_LAST);
  wire in_bit = master ? miso_s : mosi_s;

  // ========================================
  // transfer start and stop
  wire start_m = master & ~active_q & (tmode ? tx_full_q : rx_read);
  wire start_s = slave & ~active_q & ss_prev_q & ~ss_s;
  wire start = start_m | start_s;
  wire abort = active_q & (~en | (~ctrl_q[`CT_MASTER] & ss_s));
  wire undf_evt = start & ~tx_full_q;
  wire [7:0] load_byte = tx_full_q ? tx_hold_q : (umode ? last_tx_q : 8'h00);

  reg [7:0] tx_sh_d;
  reg [7:0] rx_sh_d;

  always @* begin
    tx_sh_d = tx_sh_q;
    rx_sh_d = rx_sh_q;
    if (start) begin
      tx_sh_d = load_byte;
    end else if (shift) begin
      tx_sh_d = lsb ? {1'b0, tx_sh_q[7:1]} : {tx_sh_q[6:0], 1'b0};
    end
    if (sample) begin
      rx_sh_d = lsb ? {in_bit, rx_sh_q[7:1]} : {rx_sh_q[6:0], in_bit};
    end
  end

  wire active_d = start | (active_q & ~done & ~abort);
  wire out_bit = lsb ? tx_sh_d[0] : tx_sh_d[7];

  // ========================================
  // flags
  wire ovf_evt = done & rx_full_q & ~rx_read;
  wire rx_load = done & (~rx_full_q | rx_read | ovw);
  wire rx_full_d = rx_load | (rx_full_q & ~rx_read);
  wire ovf_d = ovf_evt | (ovf_q & ~rx_read);
  wire rx_irq_d = rx_full_d | ovf_d;
  wire tx_full_d = tx_write | (tx_full_q & ~start);
  wire busy_d = tx_write | (busy_q & ~((done | abort) & ~tx_full_q));
  wire undf_d = undf_evt | (undf_q & ~tx_write);
  wire tx_irq_d = (~busy_d | undf_d) & (en | busy_d);

  wire [7:0] status = {2'b00, ovf_q, rx_irq_q, rx_full_q, undf_q, tx_irq_q, busy_q};

  // ========================================
  // interrupt events
  wire [3:0] ev;
  assign ev[`IS_RX] = rx_load & (~master | ~tmode);
  assign ev[`IS_TX] = done & (~master | tmode);
  assign ev[`IS_OVF] = ovf_evt;
  assign ev[`IS_UNDF] = undf_evt;
  wire [3:0] istat_d = (istat_q & ~{4{istat_read}}) | ev;

  // ========================================
  // read mux
  reg [31:0] rdata_d;

  always @* begin
    rdata_d = 32'h0000_0000;
    case (address_in)
      `ADDR_STATUS: rdata_d = {24'h00_0000, status};
      `ADDR_RX: rdata_d = {24'h00_0000, rx_q};
      `ADDR_DIV: rdata_d = {24'h00_0000, div_q};
      `ADDR_CTRL: rdata_d = {23'h00_0000, ctrl_q};
      `ADDR_ISTAT: rdata_d = {28'h000_0000, istat_q};
      `ADDR_IMASK: rdata_d = {28'h000_0000, imask_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // ========================================
  // registers
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h0000_0000;
      ctrl_q <= `RST_CTRL;
      div_q <= `RST_DIV;
      rx_q <= `RST_RX;
      tx_hold_q <= 8'h00;
      last_tx_q <= 8'h00;
      tx_full_q <= 1'b0;
      busy_q <= 1'b0;
      undf_q <= 1'b0;
      tx_irq_q <= 1'b0;
      rx_full_q <= 1'b0;
      ovf_q <= 1'b0;
      rx_irq_q <= 1'b0;
      istat_q <= `RST_IRQ;
      imask_q <= `RST_IRQ;
      irq_q <= 1'b0;
      active_q <= 1'b0;
      half_q <= 4'h0;
      tx_sh_q <= 8'h00;
      rx_sh_q <= 8'h00;
      sclk_prev_q <= 1'b0;
      ss_prev_q <= 1'b1;
      sclk_q <= 1'b0;
      sclk_oe_q <= 1'b0;
      mosi_q <= 1'b0;
      mosi_oe_q <= 1'b0;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
      ss_n_q <= 1'b1;
    end else if (ce_in) begin
      waitrequest_q <= ~acc;
      if (rd_acc) begin
        readdata_q <= rdata_d;
      end
      if (ctrl_write) begin
        ctrl_q <= writedata_in[8:0];
      end
      if (div_write) begin
        div_q <= writedata_in[7:0];
      end
      if (imask_write) begin
        imask_q <= writedata_in[3:0];
      end
      if (tx_write) begin
        tx_hold_q <= writedata_in[7:0];
      end
      if (start) begin
        last_tx_q <= load_byte;
      end
      if (rx_load) begin
        rx_q <= rx_sh_d;
      end
      tx_full_q <= tx_full_d;
      busy_q <= busy_d;
      undf_q <= undf_d;
      tx_irq_q <= tx_irq_d;
      rx_full_q <= rx_full_d;
      ovf_q <= ovf_d;
      rx_irq_q <= rx_irq_d;
      istat_q <= istat_d;
      irq_q <= |(istat_d & imask_q);
      active_q <= active_d;
      if (start) begin
        half_q <= `HALF_FIRST;
      end else if (edge_ev) begin
        half_q <= half_q + 4'h1;
      end
      tx_sh_q <= tx_sh_d;
      rx_sh_q <= rx_sh_d;
      sclk_prev_q <= sclk_s;
      ss_prev_q <= ss_s;
      if (!(active_d & master)) begin
        sclk_q <= cpol;
      end else if (edge_ev) begin
        sclk_q <= ~sclk_q;
      end
      sclk_oe_q <= master;
      mosi_oe_q <= master;
      miso_oe_q <= slave & ~ss_s;
      mosi_q <= out_bit;
      miso_q <= out_bit;
      ss_n_q <= ~(master & active_d);
    end
  end

  // ========================================
  // outputs
  assign readdata_out = readdata_q;
  assign waitrequest_out = waitrequest_q;
  assign irq_out = irq_q;
  assign sclk_out = sclk_q;
  assign sclk_oe_out = sclk_oe_q;
  assign mosi_out = mosi_q;
  assign mosi_oe_out = mosi_oe_q;
  assign miso_out = miso_q;
  assign miso_oe_out = miso_oe_q;
  assign ss_n_out = ss_n_q;

endmodule

`default_nettype wire

// ### dv/serial_if_regs_asserts.sv
// port assertions of the serial interface register block
`timescale 1ns/1ns
`default_nettype none
`include "serial_if_map.vh"
// ========================================
// checker
module serial_if_regs_asserts (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [31:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] readdata_out,
  input wire logic waitrequest_out,
  input wire logic sclk_oe_out,
  input wire logic mosi_oe_out,
  input wire logic ss_n_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  logic st_q;
  logic rx_q;
  // remembers whether the pending read targets the status or the rx register
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      st_q <= 1'b0;
      rx_q <= 1'b0;
    end else begin
      st_q <= read_in && address_in == `ADDR_STATUS;
      rx_q <= read_in && address_in == `ADDR_RX;
    end
  end
  AST_WAIT_ONE: assert property (!waitrequest_out |=> waitrequest_out)
    else $error("waitrequest low too long");
  AST_ANSWER: assert property (ce_in && (read_in || write_in) && waitrequest_out |=>
    !waitrequest_out) else $error("access not answered");
  AST_ST_RSV: assert property (!waitrequest_out && st_q |-> readdata_out[31:6] == 0)
    else $error("status upper bits set");
  AST_RX_IRQ: assert property (!waitrequest_out && st_q |->
    readdata_out[4] == (readdata_out[3] | readdata_out[5])) else $error("rx irq bit wrong");
  AST_TX_IRQ: assert property (!waitrequest_out && st_q && readdata_out[2] |->
    readdata_out[1]) else $error("tx irq bit wrong");
  AST_OVF_FULL: assert property (!waitrequest_out && st_q && readdata_out[5] |->
    readdata_out[3]) else $error("overflow without full");
  AST_RX_WIDTH: assert property (!waitrequest_out && rx_q |-> readdata_out[31:8] == 0)
    else $error("rx upper bits set");
  AST_FRAME: assert property ($fell(ss_n_out) |-> !ss_n_out [*8])
    else $error("frame too short");
  AST_OE: assert property (!ss_n_out |-> sclk_oe_out && mosi_oe_out)
    else $error("frame without drive");
endmodule
`default_nettype wire

// ### dv/serial_slave_model.sv
// behavioural serial slave facing the block in master mode
`timescale 1ns/1ns
`default_nettype none
// ========================================
// slave, idle-low clock, msb first
module serial_slave_model (
  input wire logic sclk_in,
  input wire logic ss_n_in,
  input wire logic mosi_in,
  input wire logic [7:0] reply_in,
  output logic miso_out,
  output logic [7:0] got_out
);
  logic [7:0] sh;
  initial miso_out = 1'b0;
  always @(negedge ss_n_in) begin
    sh = reply_in;
    miso_out = reply_in[7];
  end
  always @(posedge sclk_in) if (!ss_n_in) got_out = {got_out[6:0], mosi_in};
  always @(negedge sclk_in) if (!ss_n_in) begin
    sh = {sh[6:0], 1'b0};
    miso_out = sh[7];
  end
  // released line shows the inverse of the last bit
  always @(posedge ss_n_in) miso_out = ~miso_out;
endmodule
`default_nettype wire

// ### dv/spi_status_data_regs_tb.sv
// self-checking bench of the serial interface register block
`timescale 1ns/1ns
`default_nettype none
`include "serial_if_map.vh"
// ========================================
// bench top
module spi_status_data_regs_tb;
  logic clk_sys_in, rst_n_in, read_in, write_in, waitrequest_out, irq_out, miso_in;
  logic sclk_out, sclk_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out, ss_n_out;
  logic [31:0] address_in, writedata_in, readdata_out, rd;
  logic [7:0] reply, got, seen;
  logic sclk_pin, mosi_pin, ss_n_pin;
  int mismatches, checks, cycles;
  logic [31:0] rows [0:4][0:1] = '{'{`ADDR_STATUS, `RST_STATUS}, '{`ADDR_RX, `RST_RX},
    '{`ADDR_DIV, `RST_DIV}, '{`ADDR_TX, 32'h0000_0000}, '{32'hffff_0a40, 32'h0000_0000}};
  serial_if_regs u_serial_if_regs (.clk_sys_in, .rst_n_in, .ce_in(1'b1), .address_in,
    .read_in, .write_in, .writedata_in, .readdata_out, .waitrequest_out, .irq_out,
    .sclk_in(sclk_pin), .sclk_out, .sclk_oe_out, .mosi_in(mosi_pin), .mosi_out, .mosi_oe_out,
    .miso_in, .miso_out, .miso_oe_out, .ss_n_in(ss_n_pin), .ss_n_out);
  serial_slave_model u_serial_slave_model (.sclk_in(sclk_out), .ss_n_in(ss_n_out),
    .mosi_in(mosi_out), .reply_in(reply), .miso_out(miso_in), .got_out(got));
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  task conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    read_in <= !w;
    write_in <= w;
    address_in <= a;
    writedata_in <= d;
    @(posedge clk_sys_in);
    while (waitrequest_out !== 1'b0 && n < 20) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n == 20) mismatches++;
    rd = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task poll(input logic [31:0] exp);
    int n;
    n = 0;
    bus(0, `ADDR_STATUS, 0);
    while (rd !== exp && n < 100) begin
      bus(0, `ADDR_STATUS, 0);
      n++;
    end
  endtask
  initial begin
    rst_n_in = 1'b0;
    read_in = 1'b0;
    write_in = 1'b0;
    address_in = 32'h0000_0000;
    writedata_in = 32'h0000_0000;
    reply = 8'h00;
    seen = 8'h00;
    sclk_pin = 1'b0;
    mosi_pin = 1'b0;
    ss_n_pin = 1'b1;
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    for (int i = 0; i < 5; i++) begin
      bus(0, rows[i][0], 0);
      chk(rd, rows[i][1], "reset value");
    end
    $display("test reset values done");
    bus(1, 32'hffff_0a40, 32'h0000_00ff);
    bus(0, 32'hffff_0a40, 0);
    chk(rd, 32'h0000_0000, "unmapped");
    bus(1, `ADDR_DIV, 32'h0000_0003);
    bus(0, `ADDR_DIV, 0);
    chk(rd, 32'h0000_0003, "divider");
    bus(1, `ADDR_IMASK, 32'h0000_0002);
    bus(1, `ADDR_CTRL, 32'h0000_0043);
    bus(0, `ADDR_STATUS, 0);
    chk(rd, 32'h0000_0002, "idle status");
    reply = 8'h3c;
    bus(1, `ADDR_TX, 32'h0000_00a5);
    bus(0, `ADDR_STATUS, 0);
    chk(rd, 32'h0000_0001, "busy status");
    poll(32'h0000_001a);
    chk(rd, 32'h0000_001a, "done status");
    chk(32'(got), 32'h0000_00a5, "sent byte");
    chk(32'(irq_out), 32'h0000_0001, "irq on");
    bus(0, `ADDR_ISTAT, 0);
    chk(rd, 32'h0000_0002, "irq status");
    chk(32'(irq_out), 32'h0000_0000, "irq off");
    $display("test transmit done");
    bus(1, `ADDR_IMASK, 32'h0000_0000);
    reply = 8'h81;
    bus(1, `ADDR_TX, 32'h0000_005a);
    poll(32'h0000_003a);
    chk(rd, 32'h0000_003a, "overflow status");
    chk(32'(irq_out), 32'h0000_0000, "irq masked");
    bus(0, `ADDR_RX, 0);
    chk(rd, 32'h0000_003c, "kept byte");
    bus(0, `ADDR_STATUS, 0);
    chk(rd, 32'h0000_0002, "cleared status");
    bus(0, `ADDR_ISTAT, 0);
    chk(rd, 32'h0000_0006, "irq status ovf");
    bus(1, `ADDR_CTRL, 32'h0000_0000);
    bus(0, `ADDR_STATUS, 0);
    chk(rd, 32'h0000_0000, "disabled status");
    $display("test overflow done");
    bus(1, `ADDR_CTRL, 32'h0000_0003);
    reply = 8'hc3;
    bus(0, `ADDR_RX, 0);
    poll(32'h0000_001e);
    chk(rd, 32'h0000_001e, "underflow status");
    chk(32'(got), 32'h0000_0000, "zero byte");
    bus(1, `ADDR_TX, 32'h0000_0077);
    bus(0, `ADDR_STATUS, 0);
    chk(rd, 32'h0000_0019, "held byte");
    reply = 8'h18;
    bus(0, `ADDR_RX, 0);
    chk(rd, 32'h0000_00c3, "rx byte");
    poll(32'h0000_001a);
    chk(rd, 32'h0000_001a, "read start");
    chk(32'(got), 32'h0000_0077, "held sent");
    $display("test underflow done");
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    bus(0, `ADDR_DIV, 0);
    chk(rd, 32'h0000_001b, "divider reset");
    $display("test mid reset done");
    // slave mode, idle-low clock, msb first, bench drives the pins
    bus(1, `ADDR_CTRL, 32'h0000_0001);
    bus(1, `ADDR_TX, 32'h0000_0096);
    ss_n_pin <= 1'b0;
    for (int b = 7; b >= 0; b--) begin
      mosi_pin <= 1'(8'h6b >> b);
      repeat (8) @(posedge clk_sys_in);
      seen <= {seen[6:0], miso_out};
      sclk_pin <= 1'b1;
      repeat (8) @(posedge clk_sys_in);
      sclk_pin <= 1'b0;
    end
    repeat (8) @(posedge clk_sys_in);
    chk(32'(miso_oe_out), 32'h0000_0001, "slave drive");
    ss_n_pin <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    bus(0, `ADDR_STATUS, 0);
    chk(rd, 32'h0000_001a, "slave status");
    bus(0, `ADDR_RX, 0);
    chk(rd, 32'h0000_006b, "slave rx");
    chk(32'(seen), 32'h0000_0096, "slave tx");
    $display("test slave done");
    conclude();
  end
endmodule
bind serial_if_regs serial_if_regs_asserts u_serial_if_regs_asserts (.clk_sys_in, .rst_n_in,
  .ce_in, .address_in, .read_in, .write_in, .readdata_out, .waitrequest_out, .sclk_oe_out,
  .mosi_oe_out, .ss_n_out);
`default_nettype wire
